/* hw/hlb_line.sv */
// Line coding, clock recovery and bus access of one serial channel
`timescale 1ns/1ps
// How it works
// [R1] Clock recovery counts sixteen references per bit
// [R2] Tx clock: divided reference or recovered clock
// [R3] Recovered clock samples mid-cell on falling edge
// [R4] Edges closer than 16 references: no correction
// [R5] Edge at 20-112 degrees: adjust one sixteenth
// [R6] Lone edge at count 5-10: shift 8 or 7
// [R7] Bus idle after eight ones, busy at zero
// [R8] Busy bus or no request: send ones
// [R9] Feedback mismatch aborts frame, retry later
// [R10] After success wait ten ones, then eight
// [R11] Timing 01: drive rising, check falling edge
// [R12] Timing 11: drive falling, check next falling
// [R13] Request-to-send lags data one clock period
// [R14] Bus mode forces NRZ; wired-OR feedback outside
// [R15] NRZI: change means zero, no change one
// [R16] Drive on rising, sample on falling edge
// [R17] Bus access independent of clock source
// [R18] Insert/delete one after seven zeros
// [R19] Mode and coding chosen; coding changes idle
module hlb_line (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd_in,
  input wire logic collision_feedback_in,
  output logic serial_tx_out,
  output logic rts_n_out
);
  import hlb_pkg::*;

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  logic [1:0] rxd_sync_reg; // Bit 0 is read only by bit 1
  logic [1:0] fb_sync_reg;  // Same for the bus feedback
  logic rxd_s;
  logic fb_s;

  // Two flops on each pin before any logic looks at it
  always_ff @(posedge clk) begin
    if (rst) begin
      rxd_sync_reg <= 2'h3;
      fb_sync_reg <= 2'h3;
    end else begin
      rxd_sync_reg <= {rxd_sync_reg[0], rxd_in};
      fb_sync_reg <= {fb_sync_reg[0], collision_feedback_in};
    end
  end
  assign rxd_s = rxd_sync_reg[1];
  assign fb_s = fb_sync_reg[1];

  // ********************************************************
  // Register file and AXI4-Lite slave
  // ********************************************************
  hlb_cfg_t cfg_reg, cfg_next;     // Software configuration
  logic aw_have_reg, aw_have_next; // Address taken, waiting
  logic w_have_reg, w_have_next;   // Data taken, waiting
  logic [3:0] aw_reg, aw_next;
  logic [31:0] wd_reg, wd_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic push;       // Byte enters the transmit buffer
  logic rx_read;    // Software reads the receive byte
  logic buf_ready;  // Buffer has room
  logic [31:0] status_word;
  logic rx_valid_reg;
  logic [7:0] rx_data_reg;
  logic coll_seen_reg;
  logic prio_low_reg;
  logic bus_idle;
  hlb_tx_state_t tx_st_reg;

  // Decode, write commit and read answer
  always_comb begin
    cfg_next = cfg_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    aw_next = aw_reg;
    wd_next = wd_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    push = 1'b0;
    rx_read = 1'b0;
    // Channels taken in either order
    if (s_axi_awvalid && awready_reg) begin
      aw_have_next = 1'b1;
      aw_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_have_next = 1'b1;
      wd_next = s_axi_wdata;
    end
    if (s_axi_bready && bvalid_reg) begin
      bvalid_next = 1'b0;
    end
    // A byte write waits for room: back-pressure reaches the bus
    if (aw_have_reg && w_have_reg && !bvalid_reg &&
        (aw_reg != ADDR_TXDATA || buf_ready)) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      unique case (aw_reg)
        ADDR_CTRL: begin
          // [R19] coding stored here, applied when idle
          cfg_next = wd_reg[6:0];
        end
        ADDR_TXDATA: begin
          push = 1'b1;
        end
        ADDR_STATUS, ADDR_RXDATA: begin
          // Read-only, writes ignored
        end
        default: begin
          bresp_next = RESP_SLVERR;
        end
      endcase
    end
    // Readies never wait on valid; they stay low while an answer waits
    awready_next = !aw_have_next && !bvalid_next;
    wready_next = !w_have_next && !bvalid_next;
    if (s_axi_rready && rvalid_reg) begin
      rvalid_next = 1'b0;
    end
    arready_next = !rvalid_next && !(s_axi_arvalid && arready_reg);
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CTRL: rdata_next = {25'h0, cfg_reg};
        ADDR_STATUS: rdata_next = status_word;
        ADDR_RXDATA: begin
          rdata_next = {23'h0, rx_valid_reg, rx_data_reg};
          rx_read = 1'b1;
        end
        default: begin
          rdata_next = 32'h0;
          rresp_next = (s_axi_araddr == ADDR_TXDATA) ?
                       RESP_OKAY : RESP_SLVERR;
        end
      endcase
    end
  end

  assign status_word = {26'h0, !buf_ready, coll_seen_reg,
                        rx_valid_reg, prio_low_reg,
                        tx_st_reg != TX_IDLE, bus_idle};

  // Bus slave registers
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg <= CTRL_RESET[6:0];
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_reg <= 4'h0;
      wd_reg <= 32'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else begin
      cfg_reg <= cfg_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      aw_reg <= aw_next;
      wd_reg <= wd_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ********************************************************
  // Two-entry transmit buffer
  // ********************************************************
  logic [7:0] buf_mem [0:1];
  logic [1:0] buf_cnt_reg, buf_cnt_next;
  logic buf_rd_reg, buf_rd_next;
  logic buf_wr_reg, buf_wr_next;
  logic pop;        // Frame sent cleanly, retire the byte
  logic buf_valid;

  assign buf_ready = buf_cnt_reg != 2'h2;
  assign buf_valid = buf_cnt_reg != 2'h0;

  // Pointer and fill level; head stays until sent without loss
  always_comb begin
    buf_wr_next = buf_wr_reg ^ push;
    buf_rd_next = buf_rd_reg ^ pop;
    buf_cnt_next = buf_cnt_reg + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      buf_cnt_reg <= 2'h0;
      buf_rd_reg <= 1'b0;
      buf_wr_reg <= 1'b0;
    end else begin
      buf_cnt_reg <= buf_cnt_next;
      buf_rd_reg <= buf_rd_next;
      buf_wr_reg <= buf_wr_next;
    end
    if (push) begin
      buf_mem[buf_wr_reg] <= wd_reg[7:0];
    end
  end

  // ********************************************************
  // Clock recovery and transmit clock
  // ********************************************************
  logic [3:0] dpll_reg, dpll_next;  // Phase within the bit
  logic [3:0] div_reg, div_next;    // Free reference divider
  logic [4:0] age_reg, age_next;    // References since last edge
  logic rxd_prev_reg;
  logic rx_edge;
  logic tx_rise;
  logic tx_fall;
  logic rx_fall;

  assign rx_edge = rxd_s != rxd_prev_reg;

  // Phase correction of the receive counter
  always_comb begin
    // [R1] one reference per clk, sixteen per bit
    dpll_next = dpll_reg + 4'h1;
    age_next = (age_reg == EDGE_GAP) ? age_reg : age_reg + 5'h1;
    div_next = div_reg + 4'h1;
    if (rx_edge) begin
      // Count from one, so an edge one bit later sees a full gap
      age_next = 5'h1;
      // [R4] close edges are interference
      if (age_reg >= EDGE_GAP) begin
        // [R5] late edge: retard, early edge: advance
        if (dpll_reg >= ADJ_LO && dpll_reg <= ADJ_HI) begin
          dpll_next = dpll_reg;
        end else if (dpll_reg > SHIFT_HI) begin
          dpll_next = dpll_reg + 4'h2;
        // [R6] lone edge mid cell: large phase shift
        end else if (dpll_reg >= SHIFT_LO) begin
          dpll_next = dpll_reg + 4'h1 +
                      (cfg_reg.phase_shift7 ? SHIFT_7 : SHIFT_8);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dpll_reg <= 4'h0;
      div_reg <= 4'h0;
      age_reg <= EDGE_GAP;
      rxd_prev_reg <= 1'b1;
    end else begin
      dpll_reg <= dpll_next;
      div_reg <= div_next;
      age_reg <= age_next;
      rxd_prev_reg <= rxd_s;
    end
  end

  // [R3] receive sample at the falling recovered edge
  assign rx_fall = dpll_reg == FALL_CNT;
  // [R2] tx clock: recovered when set, else reference / 16
  assign tx_rise = cfg_reg.tx_clock_source_sel ?
                   dpll_reg == RISE_CNT : div_reg == RISE_CNT;
  assign tx_fall = cfg_reg.tx_clock_source_sel ?
                   dpll_reg == FALL_CNT : div_reg == FALL_CNT;

  // ********************************************************
  // Transmitter and bus access
  // ********************************************************
  hlb_tx_state_t tx_st_next;
  logic line_reg, line_next;       // Level on the tx pin
  logic nrzi_reg, nrzi_next;       // Coding in force
  logic [3:0] idx_reg, idx_next;   // Next data bit
  logic [2:0] zrun_reg, zrun_next; // Zeros sent in a row
  logic [3:0] ones_reg, ones_next; // Ones seen on the bus
  logic exp_reg, exp_next;         // Level awaiting check
  logic pend_reg, pend_next;       // A check is due
  logic prio_low_next;
  logic coll_seen_next;
  logic sent_reg, sent_next;       // Bit went out in a frame
  logic rts_n_reg, rts_n_next;
  logic drive_tick;
  logic data_bit;
  logic bit_out;
  logic collide;

  // [R11] [R12] drive edge chosen by timing mode
  assign drive_tick = (cfg_reg.bus_mode &&
                       cfg_reg.bus_timing_sel == TM_FALL) ?
                      tx_fall : tx_rise;
  // [R17] bus logic uses only these ticks, any clock source
  assign bus_idle = ones_reg >= (prio_low_reg ? IDLE_ONES_LOW
                                              : IDLE_ONES);
  assign data_bit = buf_mem[buf_rd_reg][idx_reg[2:0]];
  // [R9] checked at the falling edge after driving
  assign collide = cfg_reg.bus_mode && pend_reg && tx_fall &&
                   fb_s != exp_reg;

  // Frame sequencing, collision abort and line coding
  always_comb begin
    tx_st_next = tx_st_reg;
    line_next = line_reg;
    nrzi_next = nrzi_reg;
    idx_next = idx_reg;
    zrun_next = zrun_reg;
    ones_next = ones_reg;
    exp_next = exp_reg;
    pend_next = pend_reg && !tx_fall;
    prio_low_next = prio_low_reg;
    coll_seen_next = coll_seen_reg;
    sent_next = sent_reg;
    rts_n_next = rts_n_reg;
    pop = 1'b0;
    bit_out = 1'b1;
    // [R7] count ones on the bus, first zero means busy
    if (tx_fall) begin
      ones_next = !fb_s ? 4'h0 :
                  (ones_reg == 4'hf) ? ones_reg : ones_reg + 4'h1;
    end
    unique case (tx_st_reg)
      TX_IDLE: begin
        // [R19] [R14] coding switched only here, NRZ on a bus
        nrzi_next = cfg_reg.nrzi && !cfg_reg.bus_mode;
        if (buf_valid) begin
          tx_st_next = TX_WAIT;
        end
      end
      TX_WAIT: begin
        // [R10] own frame done: ten ones needed, else eight
        if (drive_tick && (!cfg_reg.bus_mode || bus_idle)) begin
          tx_st_next = TX_SEND;
          prio_low_next = 1'b0;
          idx_next = 4'h0;
          zrun_next = 3'h0;
        end
      end
      TX_SEND: begin
        if (collide) begin
          // [R9] abort now, ones follow, retry when idle
          tx_st_next = TX_WAIT;
          coll_seen_next = 1'b1;
          line_next = 1'b1;
          pend_next = 1'b0;
        end else if (drive_tick) begin
          // [R18] one after seven zeros keeps edges coming
          if (cfg_reg.bus_mode && zrun_reg == STUFF_ZEROS) begin
            bit_out = 1'b1;
            zrun_next = 3'h0;
          end else if (idx_reg == BITS_PER_BYTE) begin
            tx_st_next = TX_IDLE;
            pop = 1'b1;
            prio_low_next = cfg_reg.bus_mode;
          end else begin
            bit_out = data_bit;
            idx_next = idx_reg + 4'h1;
            zrun_next = data_bit ? 3'h0 : zrun_reg + 3'h1;
          end
          if (tx_st_next == TX_SEND) begin
            // [R15] [R16] NRZI toggles for a zero
            line_next = nrzi_reg ? line_reg ^ !bit_out : bit_out;
            exp_next = line_next;
            pend_next = 1'b1;
          end else begin
            line_next = 1'b1;
          end
        end
      end
      default: begin
        tx_st_next = TX_IDLE;
      end
    endcase
    // [R8] outside a frame the line is held at one
    if (tx_st_next != TX_SEND && tx_st_reg != TX_SEND) begin
      line_next = 1'b1;
    end
    // [R13] request-to-send one period behind the data
    if (drive_tick) begin
      // The opening tick sends no bit, so it marks nothing
      sent_next = tx_st_reg == TX_SEND && tx_st_next == TX_SEND &&
                  !collide;
      rts_n_next = !(sent_reg && cfg_reg.rts_en &&
                     cfg_reg.bus_mode &&
                     !cfg_reg.tx_clock_source_sel);
    end
    if (collide) begin
      sent_next = 1'b0;
    end
    // Clear on status read; a new collision wins
    if (s_axi_arvalid && arready_reg &&
        s_axi_araddr == ADDR_STATUS && !collide) begin
      coll_seen_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_st_reg <= TX_IDLE;
      line_reg <= 1'b1;
      nrzi_reg <= 1'b0;
      idx_reg <= 4'h0;
      zrun_reg <= 3'h0;
      ones_reg <= 4'h0;
      exp_reg <= 1'b1;
      pend_reg <= 1'b0;
      prio_low_reg <= 1'b0;
      coll_seen_reg <= 1'b0;
      sent_reg <= 1'b0;
      rts_n_reg <= 1'b1;
    end else begin
      tx_st_reg <= tx_st_next;
      line_reg <= line_next;
      nrzi_reg <= nrzi_next;
      idx_reg <= idx_next;
      zrun_reg <= zrun_next;
      ones_reg <= ones_next;
      exp_reg <= exp_next;
      pend_reg <= pend_next;
      prio_low_reg <= prio_low_next;
      coll_seen_reg <= coll_seen_next;
      sent_reg <= sent_next;
      rts_n_reg <= rts_n_next;
    end
  end
  assign serial_tx_out = line_reg;
  assign rts_n_out = rts_n_reg;

  // ********************************************************
  // Receiver: decode and one deletion
  // ********************************************************
  logic lvl_reg, lvl_next;         // Previous sampled level
  logic [7:0] sh_reg, sh_next;
  logic [3:0] rcnt_reg, rcnt_next;
  logic [2:0] rz_reg, rz_next;     // Zeros received in a row
  logic [7:0] rx_data_next;
  logic rx_valid_next;
  logic rbit;

  // [R15] NRZI decode: unchanged level is a one
  assign rbit = nrzi_reg ? rxd_s == lvl_reg : rxd_s;

  always_comb begin
    lvl_next = lvl_reg;
    sh_next = sh_reg;
    rcnt_next = rcnt_reg;
    rz_next = rz_reg;
    rx_data_next = rx_data_reg;
    rx_valid_next = rx_valid_reg && !rx_read;
    if (rx_fall) begin
      lvl_next = rxd_s;
      // [R18] drop the inserted one after seven zeros
      if (cfg_reg.bus_mode && rz_reg == STUFF_ZEROS && rbit) begin
        rz_next = 3'h0;
      end else begin
        rz_next = rbit ? 3'h0 : rz_reg + 3'h1;
        sh_next = {rbit, sh_reg[7:1]};
        rcnt_next = rcnt_reg + 4'h1;
        if (rcnt_reg == BITS_PER_BYTE - 4'h1) begin
          rcnt_next = 4'h0;
          rx_data_next = {rbit, sh_reg[7:1]};
          // Set wins over the read that clears it
          rx_valid_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lvl_reg <= 1'b1;
      sh_reg <= 8'h0;
      rcnt_reg <= 4'h0;
      rz_reg <= 3'h0;
      rx_data_reg <= 8'h0;
      rx_valid_reg <= 1'b0;
    end else begin
      lvl_reg <= lvl_next;
      sh_reg <= sh_next;
      rcnt_reg <= rcnt_next;
      rz_reg <= rz_next;
      rx_data_reg <= rx_data_next;
      rx_valid_reg <= rx_valid_next;
    end
  end

endmodule

/* hw/hlb_pkg.sv */
// Shared constants and types of the line coding and bus access block
package hlb_pkg;

  // ********************************************************
  // Register map (byte addresses)
  // ********************************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;   // Configuration
  localparam logic [3:0] ADDR_STATUS = 4'h4; // Line and bus state
  localparam logic [3:0] ADDR_TXDATA = 4'h8; // One byte per frame
  localparam logic [3:0] ADDR_RXDATA = 4'hc; // Last received byte

  // Field positions in the status word
  localparam int ST_BUS_IDLE = 0;
  localparam int ST_TX_BUSY = 1;
  localparam int ST_PRIO_LOW = 2;
  localparam int ST_RX_VALID = 3;
  localparam int ST_COLL = 4;
  localparam int ST_TXFULL = 5;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ********************************************************
  // Timing and line constants
  // ********************************************************
  localparam logic [3:0] REF_PER_BIT = 4'hf;  // Last count of 16
  localparam logic [3:0] RISE_CNT = 4'h0;     // Clock rises
  localparam logic [3:0] FALL_CNT = 4'h8;     // Mid cell, falls
  localparam logic [4:0] EDGE_GAP = 5'h10;    // Interference span
  localparam logic [3:0] ADJ_LO = 4'h1;       // About 20 degrees
  localparam logic [3:0] ADJ_HI = 4'h4;       // About 112 degrees
  localparam logic [3:0] SHIFT_LO = 4'h5;     // Phase shift range
  localparam logic [3:0] SHIFT_HI = 4'ha;
  localparam logic [3:0] SHIFT_8 = 4'h8;      // 180 degrees
  localparam logic [3:0] SHIFT_7 = 4'h7;      // 157.5 degrees
  localparam logic [3:0] IDLE_ONES = 4'h8;    // Normal idle
  localparam logic [3:0] IDLE_ONES_LOW = 4'ha; // After own frame
  localparam logic [2:0] STUFF_ZEROS = 3'h7;  // One insertion
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] TM_RISE = 2'h1;      // Timing mode 1
  localparam logic [1:0] TM_FALL = 2'h3;      // Timing mode 2
  localparam logic [31:0] CTRL_RESET = 32'h0000_0008;

  // ********************************************************
  // Types
  // ********************************************************
  typedef struct packed {
    logic phase_shift7;        // Shift 7 counts instead of 8
    logic rts_en;              // Request-to-send in bus mode with the divided reference clock
    logic [1:0] bus_timing_sel; // 01 or 11
    logic tx_clock_source_sel; // 1: recovered clock drives tx
    logic nrzi;                // NRZI line code
    logic bus_mode;            // Point-to-multipoint access
  } hlb_cfg_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_WAIT = 3'b010,
    TX_SEND = 3'b100
  } hlb_tx_state_t;

endpackage

/* tb/hlb_chk.sv */
// Port checker for the line coding and bus access block
`timescale 1ns/1ps
// ****
// Handshake and line timing
// ****
module hlb_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic serial_tx_out,
  input wire logic rts_n_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("Write answer dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read answer moved");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late");
  read_cause_a: assert property ($rose(s_axi_rvalid)
    |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("Read answer unasked");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("Write taken while answer pending");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read taken while answer pending");
  rst_idle_a: assert property (disable iff (1'b0) rst
    |=> serial_tx_out && rts_n_out) else $error("Line not idle in reset");
  bit_hold_a: assert property ($changed(serial_tx_out)
    |=> $stable(serial_tx_out) [*7]) else $error("Line bit too short");
  rts_hold_a: assert property ($fell(rts_n_out)
    |=> !rts_n_out [*8]) else $error("Request pulse too short");
  wr_cov_c: cover property (s_axi_bvalid && s_axi_bready);
  rd_cov_c: cover property (s_axi_rvalid && s_axi_rready);
  rts_cov_c: cover property ($fell(rts_n_out));
endmodule
bind hlb_line hlb_chk u_chk (.clk, .rst, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .serial_tx_out, .rts_n_out);

/* tb/hlb_peer.sv */
// Model of the other stations sharing the wired bus
`timescale 1ns/1ps
// ****
// Wired bus
// ****
module hlb_peer (
  input wire logic clk,
  input wire logic tx_in,
  input wire logic jam,
  output logic bus_out
);
  logic peer_bit; // High while the other station is silent
  always_ff @(posedge clk) peer_bit <= !jam;
  // a zero wins on the wired bus, fed back to the station
  assign bus_out = tx_in & peer_bit;
endmodule

/* tb/tb_top.sv */
// Self-checking bench of the line coding and bus access block
`timescale 1ns/1ps
// ****
// Bench
// ****
module tb_top;
  import hlb_pkg::*;
  logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, serial_tx_out, rts_n_out, jam, bus;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] modes [6] = '{8'h00, 8'h04, 8'h02, 8'h29, 8'h39, 8'h0b};
  int seed = 8;
  int n_fail = 0;
  int n_tests = 0;
  // Line looped back so feedback and receiver see the wired bus
  hlb_line DUT (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rxd_in(bus), .collision_feedback_in(bus),
    .serial_tx_out, .rts_n_out);
  hlb_peer u_peer (.clk, .tx_in(serial_tx_out), .jam, .bus_out(bus));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wrap_up;
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Write: address and data offered together, bready held up
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Expected line level of bit i, LSB first, from an idle high line
  function automatic logic lvl(input logic [7:0] b, input logic z,
    input int i);
    logic l;
    l = 1'b1;
    for (int k = 0; k <= i; k++) l = z ? (b[k] ? l : ~l) : b[k];
    return l;
  endfunction
  // Bit zero is always 0, so the first falling edge opens the frame
  task fall;
    int t;
    t = 0;
    while (serial_tx_out !== 1'b0 && t < 4000) begin
      @(posedge clk);
      t++;
    end
  endtask
  task cap(input logic [7:0] b, input logic z, input logic r);
    fall();
    repeat (8) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      chk(serial_tx_out, lvl(b, z, i));
      if (r && i < 2) chk(rts_n_out, i == 0);
      repeat (16) @(posedge clk);
    end
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] b, b2;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, jam} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 10'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, d, r);
    chk(d, CTRL_RESET);
    rd(4'h2, d, r);
    chk(r, RESP_SLVERR);
    foreach (modes[m]) begin
      wr(ADDR_CTRL, {24'h0, modes[m]});
      b = ($random(seed) & 8'hfe) | 8'h02;
      wr(ADDR_TXDATA, {24'h0, b});
      cap(b, modes[m] == 8'h02, modes[m][5]);
      if (modes[m][0]) begin
        rd(ADDR_STATUS, d, r);
        chk(d[ST_PRIO_LOW], 1'b1);
      end
    end
    wr(ADDR_CTRL, 32'h29);
    b = ($random(seed) & 8'hfe) | 8'h02;
    b2 = ($random(seed) & 8'hfe) | 8'h02;
    wr(ADDR_TXDATA, {24'h0, b});
    fall();
    jam <= 1'b1;
    repeat (40) @(posedge clk);
    chk(serial_tx_out, 1'b1);
    wr(ADDR_TXDATA, {24'h0, b2});
    rd(ADDR_STATUS, d, r);
    chk(d[ST_COLL], 1'b1);
    chk(d[ST_TXFULL], 1'b1);
    chk(serial_tx_out, 1'b1);
    jam <= 1'b0;
    cap(b, 1'b0, 1'b1);
    cap(b2, 1'b0, 1'b1);
    // Receiver has sampled the looped line for many bytes by now
    rd(ADDR_RXDATA, d, r);
    chk(d[8], 1'b1);
    wrap_up();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
endmodule
